// ---- hw/dpu_pkg.sv ----
/*
  dpu_pkg: constants, register layout and operation codes of the dual
  pointer update unit.
  Assumes: a single 20 MHz system clock and a classic Wishbone register bus
  whose byte address is four times the register index.
*/
// Operation
// - pointer-0 decrement bit turns pointer increment of pointer 0 into decrement.
// - pointer-1 decrement bit turns pointer increment of pointer 1 into decrement.
// - select bit 0: normal operand is pointer 0, alternate is pointer 1; 1 swaps.
// - pointer-0 auto-update post-steps pointer 0 after data or code moves.
// - pointer-1 auto-update post-steps pointer 1 after data or code moves.
// - signature enable steers pointer code reads and programming accesses to signature.
// - b redirect makes moves through pointer 1 use register B, not accumulator.
// - code index disable drops the accumulator offset from indexed code reads.
// - b redirect never replaces the accumulator as code read index.
// - each pointer has its own circular enable, both may use either region.
// - buffer length is an 8-bit register at index e3, up to 256 entries.
// - region A spans 0000 to length, region B 0100 to 0100 plus length.
// - circular increment at end of a region wraps to its start.
// - circular decrement at start of a region wraps to its end.
// - wrapping applies to explicit steps and auto-updates, direction from decrement bits.
// - at all other addresses an enabled pointer steps normally.
// - config bits 2 and 1 read zero so incrementing config toggles only select.
// - prefixed pointer operations use the inverted select, except the indirect jump.
package dpu_pkg;

  // register indices; byte address on the bus is index times four
  localparam logic [7:0] DPU_IDX_PTR0_LO = 8'h82;
  localparam logic [7:0] DPU_IDX_PTR0_HI = 8'h83;
  localparam logic [7:0] DPU_IDX_PTR1_LO = 8'h84;
  localparam logic [7:0] DPU_IDX_PTR1_HI = 8'h85;
  localparam logic [7:0] DPU_IDX_PTR_CFG = 8'ha2;
  localparam logic [7:0] DPU_IDX_SP_CFG = 8'he2;
  localparam logic [7:0] DPU_IDX_BUF_LEN = 8'he3;
  localparam int DPU_ADR_W = 10;

  // pointer_config fields
  localparam int DPU_PC_SEL = 0;
  localparam int DPU_PC_SIG = 3;
  localparam int DPU_PC_DEC0 = 4;
  localparam int DPU_PC_DEC1 = 5;
  localparam int DPU_PC_AUP0 = 6;
  localparam int DPU_PC_AUP1 = 7;
  localparam logic [7:0] DPU_PC_WMASK = 8'hf9;
  localparam logic [7:0] DPU_PC_RESET = 8'h00;

  // signal_processing_config fields
  localparam int DPU_SP_BRD = 0;
  localparam int DPU_SP_CID = 1;
  localparam int DPU_SP_PTR0_CIRCULAR_ENABLE = 2;
  localparam int DPU_SP_PTR1_CIRCULAR_ENABLE = 3;
  localparam logic [7:0] DPU_SP_RESET = 8'h00;
  localparam logic [7:0] DPU_LEN_RESET = 8'h00;

  // circular region bases (high byte of pointer)
  localparam logic [7:0] DPU_REG_A_HI = 8'h00;
  localparam logic [7:0] DPU_REG_B_HI = 8'h01;
  localparam logic [15:0] DPU_PTR_RESET = 16'h0000;
  localparam logic [15:0] DPU_ONE = 16'h0001;

  // operation codes from the execution core
  typedef enum logic [2:0] {
    DPU_OP_NONE = 3'h0,
    DPU_OP_STEP = 3'h1,
    DPU_OP_XRD = 3'h2,
    DPU_OP_XWR = 3'h3,
    DPU_OP_CRD = 3'h4,
    DPU_OP_LOAD = 3'h5,
    DPU_OP_JMP = 3'h6
  } dpu_op_t;

  // memory space of an access
  typedef enum logic [1:0] {
    DPU_SP_NONE = 2'h0,
    DPU_SP_XDATA = 2'h1,
    DPU_SP_CODE = 2'h2,
    DPU_SP_SIGN = 2'h3
  } dpu_space_t;

endpackage : dpu_pkg

// ---- hw/dpu_step.sv ----
/*
  dpu_step: next value of one pointer for an increment or decrement, with
  optional circular wrap over the two regions.
  Assumes: purely combinational use; the caller registers the result.
*/
`timescale 1ns/100ps
module dpu_step
  import dpu_pkg::*;
(
  input wire logic [15:0] ptr,
  input wire logic dec,
  input wire logic circ,
  input wire logic [7:0] len,
  output logic [15:0] nxt
);

  // full 16-bit compares, so e.g. 0200 never wraps
  always_comb begin
    nxt = dec ? ptr - DPU_ONE : ptr + DPU_ONE;
    if (circ) begin
      if (!dec && ptr == {DPU_REG_A_HI, len}) begin
        nxt = {DPU_REG_A_HI, 8'h00};
      end else if (!dec && ptr == {DPU_REG_B_HI, len}) begin
        nxt = {DPU_REG_B_HI, 8'h00};
      end else if (dec && ptr == {DPU_REG_A_HI, 8'h00}) begin
        nxt = {DPU_REG_A_HI, len};
      end else if (dec && ptr == {DPU_REG_B_HI, 8'h00}) begin
        nxt = {DPU_REG_B_HI, len};
      end
    end
  end

endmodule : dpu_step

// ---- hw/dpu_addr_gen.sv ----
/*
  dpu_addr_gen: address, memory space and data register steering of one
  pointer operation.
  Assumes: the caller resolves which pointer is used and registers outputs.
*/
`timescale 1ns/100ps
module dpu_addr_gen
  import dpu_pkg::*;
(
  input wire dpu_op_t op,
  input wire logic [15:0] ptr,
  input wire logic use_p1,
  input wire logic [7:0] acc,
  input wire logic sig_en,
  input wire logic b_redirect,
  input wire logic code_index_disable,
  output logic [15:0] addr,
  output dpu_space_t space,
  output logic use_b
);

  // the accumulator stays the index even when b is the destination
  always_comb begin
    addr = ptr;
    space = DPU_SP_NONE;
    use_b = 1'b0;
    case (op)
      DPU_OP_XRD, DPU_OP_XWR: begin
        space = DPU_SP_XDATA;
        use_b = use_p1 & b_redirect;
      end
      DPU_OP_CRD: begin
        addr = code_index_disable ? ptr : ptr + {8'h00, acc};
        space = sig_en ? DPU_SP_SIGN : DPU_SP_CODE;
        use_b = use_p1 & b_redirect;
      end
      DPU_OP_JMP: begin
        addr = ptr + {8'h00, acc};
        space = DPU_SP_CODE;
      end
      default: begin
        addr = ptr;
      end
    endcase
  end

endmodule : dpu_addr_gen

// ---- hw/dpu_top.sv ----
/*
  dpu_top: dual 16-bit pointers with select, step direction, auto-update,
  circular regions and b redirect, plus a classic Wishbone register slave.
  Assumes: the execution core presents one operation per cycle as a pulse
  on op_valid; software writes configuration over Wishbone.
*/
`timescale 1ns/100ps
module dpu_top
  import dpu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DPU_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // operation port from the execution core
  input wire logic op_valid,
  input wire dpu_op_t op_code,
  input wire logic op_alt,
  input wire logic [7:0] op_acc,
  input wire logic [15:0] op_imm,
  // results
  output logic [15:0] mem_addr,
  output dpu_space_t mem_space,
  output logic mem_use_b,
  output logic op_done,
  output logic iap_to_signature,
  output logic [15:0] pointer_0,
  output logic [15:0] pointer_1
);

  logic [7:0] pointer_config_q;
  logic [7:0] signal_processing_config_q;
  logic [7:0] circular_buffer_length_q;
  logic [15:0] ptr0_q;
  logic [15:0] ptr1_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [15:0] addr_q;
  dpu_space_t space_q;
  logic use_b_q;
  logic done_q;
  logic iap_sig_q;

  logic bus_req;
  logic bus_wr;
  logic [7:0] bus_idx;
  logic sel_bit;
  logic use_p1;
  logic [15:0] sel_ptr;
  logic [15:0] step0;
  logic [15:0] step1;
  logic [15:0] gen_addr;
  dpu_space_t gen_space;
  logic gen_use_b;
  logic is_move;
  logic upd0;
  logic upd1;
  logic ld0;
  logic ld1;

  // register index from a byte address; low two bits must be zero
  function automatic logic [7:0] dpu_index(input logic [DPU_ADR_W-1:0] adr);
    dpu_index = adr[DPU_ADR_W-1:2];
  endfunction : dpu_index

  function automatic logic dpu_hit(input logic [DPU_ADR_W-1:0] adr,
                                   input logic [7:0] idx);
    dpu_hit = (adr[1:0] == 2'b00) && (dpu_index(adr) == idx);
  endfunction : dpu_hit

  // a request is served once; ack drops the cycle after it rose
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_idx = dpu_index(wb_adr_i);

  // pointer resolution; the indirect jump ignores the prefix
  assign sel_bit = pointer_config_q[DPU_PC_SEL] ^ (op_alt && op_code != DPU_OP_JMP);
  assign use_p1 = sel_bit;
  assign sel_ptr = use_p1 ? ptr1_q : ptr0_q;

  // step units, one per pointer, each with its own circular enable
  dpu_step u_step0 (
    .ptr(ptr0_q),
    .dec(pointer_config_q[DPU_PC_DEC0]),
    .circ(signal_processing_config_q[DPU_SP_PTR0_CIRCULAR_ENABLE]),
    .len(circular_buffer_length_q),
    .nxt(step0)
  );

  dpu_step u_step1 (
    .ptr(ptr1_q),
    .dec(pointer_config_q[DPU_PC_DEC1]),
    .circ(signal_processing_config_q[DPU_SP_PTR1_CIRCULAR_ENABLE]),
    .len(circular_buffer_length_q),
    .nxt(step1)
  );

  dpu_addr_gen u_addr (
    .op(op_code),
    .ptr(sel_ptr),
    .use_p1(use_p1),
    .acc(op_acc),
    .sig_en(pointer_config_q[DPU_PC_SIG]),
    .b_redirect(signal_processing_config_q[DPU_SP_BRD]),
    .code_index_disable(signal_processing_config_q[DPU_SP_CID]),
    .addr(gen_addr),
    .space(gen_space),
    .use_b(gen_use_b)
  );

  // which pointer changes this cycle
  always_comb begin
    is_move = (op_code == DPU_OP_XRD) || (op_code == DPU_OP_XWR) || (op_code == DPU_OP_CRD);
    upd0 = 1'b0;
    upd1 = 1'b0;
    ld0 = 1'b0;
    ld1 = 1'b0;
    if (op_valid) begin
      if (op_code == DPU_OP_STEP) begin
        upd0 = ~use_p1;
        upd1 = use_p1;
      end else if (is_move) begin
        upd0 = ~use_p1 & pointer_config_q[DPU_PC_AUP0];
        upd1 = use_p1 & pointer_config_q[DPU_PC_AUP1];
      end else if (op_code == DPU_OP_LOAD) begin
        ld0 = ~use_p1;
        ld1 = use_p1;
      end
    end
  end

  // pointer 0: core operation beats a bus write in the same cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ptr0_q <= DPU_PTR_RESET;
    end else if (upd0) begin
      ptr0_q <= step0;
    end else if (ld0) begin
      ptr0_q <= op_imm;
    end else if (bus_wr && dpu_hit(wb_adr_i, DPU_IDX_PTR0_LO)) begin
      ptr0_q[7:0] <= wb_dat_i[7:0];
    end else if (bus_wr && dpu_hit(wb_adr_i, DPU_IDX_PTR0_HI)) begin
      ptr0_q[15:8] <= wb_dat_i[7:0];
    end
  end

  // pointer 1: same priority as pointer 0
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ptr1_q <= DPU_PTR_RESET;
    end else if (upd1) begin
      ptr1_q <= step1;
    end else if (ld1) begin
      ptr1_q <= op_imm;
    end else if (bus_wr && dpu_hit(wb_adr_i, DPU_IDX_PTR1_LO)) begin
      ptr1_q[7:0] <= wb_dat_i[7:0];
    end else if (bus_wr && dpu_hit(wb_adr_i, DPU_IDX_PTR1_HI)) begin
      ptr1_q[15:8] <= wb_dat_i[7:0];
    end
  end

  // pointer_config; bits 2 and 1 never store, so an increment only toggles select
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pointer_config_q <= DPU_PC_RESET;
    end else if (bus_wr && dpu_hit(wb_adr_i, DPU_IDX_PTR_CFG)) begin
      pointer_config_q <= wb_dat_i[7:0] & DPU_PC_WMASK;
    end
  end

  // signal_processing_config; upper bits belong to the multiplier but are held here
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      signal_processing_config_q <= DPU_SP_RESET;
    end else if (bus_wr && dpu_hit(wb_adr_i, DPU_IDX_SP_CFG)) begin
      signal_processing_config_q <= wb_dat_i[7:0];
    end
  end

  // circular_buffer_length; all 8 bits give up to 256 entries
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      circular_buffer_length_q <= DPU_LEN_RESET;
    end else if (bus_wr && dpu_hit(wb_adr_i, DPU_IDX_BUF_LEN)) begin
      circular_buffer_length_q <= wb_dat_i[7:0];
    end
  end

  // bus answer: one wait state, unmapped addresses read zero and still ack
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      if (bus_req) begin
        rdata_q <= 32'h0000_0000;
        if (wb_adr_i[1:0] == 2'b00) begin
          case (bus_idx)
            DPU_IDX_PTR0_LO: rdata_q[7:0] <= ptr0_q[7:0];
            DPU_IDX_PTR0_HI: rdata_q[7:0] <= ptr0_q[15:8];
            DPU_IDX_PTR1_LO: rdata_q[7:0] <= ptr1_q[7:0];
            DPU_IDX_PTR1_HI: rdata_q[7:0] <= ptr1_q[15:8];
            DPU_IDX_PTR_CFG: rdata_q[7:0] <= pointer_config_q;
            DPU_IDX_SP_CFG: rdata_q[7:0] <= signal_processing_config_q;
            DPU_IDX_BUF_LEN: rdata_q[7:0] <= circular_buffer_length_q;
            default: rdata_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // access result, registered one cycle after the operation
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= DPU_PTR_RESET;
      space_q <= DPU_SP_NONE;
      use_b_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= op_valid && op_code != DPU_OP_NONE;
      if (op_valid) begin
        addr_q <= gen_addr; // address uses the pointer before its post-update
        space_q <= gen_space;
        use_b_q <= gen_use_b;
      end
    end
  end

  // programming accesses follow the signature enable as a level
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      iap_sig_q <= 1'b0;
    end else begin
      iap_sig_q <= pointer_config_q[DPU_PC_SIG];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign mem_addr = addr_q;
  assign mem_space = space_q;
  assign mem_use_b = use_b_q;
  assign op_done = done_q;
  assign iap_to_signature = iap_sig_q;
  assign pointer_0 = ptr0_q;
  assign pointer_1 = ptr1_q;

endmodule : dpu_top

// ---- bench/dpu_core_model.sv ----
/*
  dpu_core_model: execution core stand-in that issues one operation pulse.
  Assumes: dpu_pkg is compiled first; one caller at a time.
*/
`timescale 1ns/100ps
module dpu_core_model
  import dpu_pkg::*;
(
  input wire logic sys_clk,
  output logic op_valid,
  output dpu_op_t op_code,
  output logic op_alt,
  output logic [7:0] op_acc,
  output logic [15:0] op_imm
);
  // idle at time zero
  initial begin
    op_valid = 1'b0;
    op_code = DPU_OP_NONE;
    op_alt = 1'b0;
    op_acc = 8'h00;
    op_imm = 16'h0000;
  end

  // one-cycle request; a prefixed op sends op_alt high
  task issue(input dpu_op_t c, input logic a, input logic [7:0] x, input logic [15:0] i);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_alt <= a;
    op_acc <= x;
    op_imm <= i;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    op_acc <= ~x; // stale operands must not look valid
    op_imm <= ~i;
  endtask : issue
endmodule : dpu_core_model

// ---- bench/dpu_checker.sv ----
/*
  dpu_checker: protocol and pointer relations seen at the unit's ports.
  Assumes: bound to dpu_top; single clock domain.
*/
`timescale 1ns/100ps
module dpu_checker
  import dpu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [DPU_ADR_W-1:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic op_valid,
  input wire dpu_op_t op_code,
  input wire logic [15:0] op_imm,
  input wire logic [15:0] mem_addr,
  input wire dpu_space_t mem_space,
  input wire logic mem_use_b,
  input wire logic op_done,
  input wire logic [15:0] pointer_0,
  input wire logic [15:0] pointer_1
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_rdata_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_cfg_low_zero: assert property (wb_ack_o && wb_adr_i == {DPU_IDX_PTR_CFG, 2'b00}
    |-> wb_dat_o[2:1] == 2'b00) else $error("config bits 2 and 1 not zero");
  a_done_after_op: assert property (op_valid && op_code != DPU_OP_NONE |=> op_done)
    else $error("op_done missing");
  a_no_spurious_done: assert property (!(op_valid && op_code != DPU_OP_NONE) |=> !op_done)
    else $error("op_done without operation");
  a_load_one_ptr: assert property (op_valid && op_code == DPU_OP_LOAD |=>
    pointer_0 == $past(op_imm) || pointer_1 == $past(op_imm)) else $error("load lost");
  a_xdata_old_ptr: assert property (op_valid && op_code inside {DPU_OP_XRD, DPU_OP_XWR}
    |=> mem_space == DPU_SP_XDATA && (mem_addr == $past(pointer_0) ||
    mem_addr == $past(pointer_1))) else $error("move address not the old pointer");
  a_step_one_ptr: assert property (op_valid && op_code == DPU_OP_STEP |=>
    $stable(pointer_0) || $stable(pointer_1)) else $error("step moved both pointers");
  a_jump_keeps_ptr: assert property (op_valid && op_code == DPU_OP_JMP |=>
    mem_space == DPU_SP_CODE && !mem_use_b && $stable(pointer_0) && $stable(pointer_1))
    else $error("jump misbehaved");

  c_code_read: cover property (op_valid && op_code == DPU_OP_CRD);
  c_b_redirect: cover property (op_done && mem_use_b);
  c_bus_ack: cover property (wb_ack_o);
endmodule : dpu_checker

bind dpu_top dpu_checker u_chk (.sys_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_ack_o,
  .wb_dat_o,
  .op_valid, .op_code, .op_imm, .mem_addr, .mem_space, .mem_use_b, .op_done, .pointer_0,
  .pointer_1);

// ---- bench/dual_pointer_update_unit_test.sv ----
/*
  dual_pointer_update_unit_test: model-compared bench of dpu_top.
  Assumes: dpu_pkg, design files, core model and checker compiled first.
*/
`timescale 1ns/100ps
module dual_pointer_update_unit_test;
  import dpu_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, op_valid, op_alt;
  logic [DPU_ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r, seed = 32'hf281;
  logic [7:0] op_acc, m_cfg = 8'h00, m_sp = 8'h00, m_len = 8'h00;
  logic [15:0] op_imm, mem_addr, pointer_0, pointer_1, imm;
  logic [15:0] m_p [2] = '{16'h0000, 16'h0000};
  logic [7:0] idx_tab [8] = '{DPU_IDX_PTR0_LO, DPU_IDX_PTR0_HI, DPU_IDX_PTR1_LO,
    DPU_IDX_PTR1_HI, DPU_IDX_PTR_CFG, DPU_IDX_SP_CFG, DPU_IDX_BUF_LEN, 8'h10};
  dpu_op_t op_code;
  dpu_space_t mem_space;
  logic mem_use_b, op_done, iap_to_signature;
  int fail_count = 0, n_tests = 0;

  dpu_core_model core (.sys_clk(sys_clk), .op_valid(op_valid), .op_code(op_code),
    .op_alt(op_alt), .op_acc(op_acc), .op_imm(op_imm));
  dpu_top uut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .op_valid(op_valid), .op_code(op_code),
    .op_alt(op_alt), .op_acc(op_acc), .op_imm(op_imm), .mem_addr(mem_addr),
    .mem_space(mem_space), .mem_use_b(mem_use_b), .op_done(op_done),
    .iap_to_signature(iap_to_signature), .pointer_0(pointer_0), .pointer_1(pointer_1));

  // 20 MHz system clock
  always #25 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // reference pointer step, full 16-bit compares only
  function automatic logic [15:0] step(logic [15:0] p, logic d, logic c);
    if (c && !d && p == {8'h00, m_len}) return 16'h0000;
    if (c && !d && p == {8'h01, m_len}) return 16'h0100;
    if (c && d && p == 16'h0000) return {8'h00, m_len};
    if (c && d && p == 16'h0100) return {8'h01, m_len};
    return d ? p - 16'h0001 : p + 16'h0001;
  endfunction : step

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk

  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  // classic single cycle; waits for ack under a bound
  task automatic wb(logic w, logic [7:0] idx, logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'hf;
    // ack and read data are taken at the rising edge where ack is seen high
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (n == 20) begin
      fail_count++;
      stop_test();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wr(logic [7:0] idx, logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
    case (idx)
      DPU_IDX_PTR0_LO: m_p[0][7:0] = d;
      DPU_IDX_PTR0_HI: m_p[0][15:8] = d;
      DPU_IDX_PTR1_LO: m_p[1][7:0] = d;
      DPU_IDX_PTR1_HI: m_p[1][15:8] = d;
      DPU_IDX_PTR_CFG: m_cfg = d & 8'hf9;
      DPU_IDX_SP_CFG: m_sp = d;
      DPU_IDX_BUF_LEN: m_len = d;
      default: ;
    endcase
  endtask : wr

  task automatic rd_all();
    logic [31:0] q;
    logic [7:0] e [8];
    e = '{m_p[0][7:0], m_p[0][15:8], m_p[1][7:0], m_p[1][15:8], m_cfg, m_sp, m_len, 8'h00};
    for (int k = 0; k < 8; k++) begin
      wb(1'b0, idx_tab[k], 8'h00, q);
      chk("register read", {24'h0, e[k]}, q);
    end
  endtask : rd_all

  // predict, issue through the core model, then compare
  task automatic do_op(dpu_op_t c, logic a, logic [7:0] x, logic [15:0] i);
    logic s;
    logic mv;
    logic [15:0] p, ea;
    s = m_cfg[0] ^ (a && c != DPU_OP_JMP);
    p = m_p[s];
    mv = c inside {DPU_OP_XRD, DPU_OP_XWR};
    ea = (c == DPU_OP_CRD && m_sp[1]) ? p : p + {8'h00, x};
    if (c == DPU_OP_STEP || (m_cfg[6 + s] && (mv || c == DPU_OP_CRD)))
      m_p[s] = step(p, m_cfg[4 + s], m_sp[2 + s]);
    if (c == DPU_OP_LOAD) m_p[s] = i;
    core.issue(c, a, x, i);
    #1;
    chk("op_done", {31'h0, c != DPU_OP_NONE}, {31'h0, op_done});
    chk("pointer_0", m_p[0], pointer_0);
    chk("pointer_1", m_p[1], pointer_1);
    chk("iap_to_signature", m_cfg[3], iap_to_signature);
    if (mv || c == DPU_OP_CRD || c == DPU_OP_JMP) begin
      chk("mem_addr", mv ? p : ea, mem_addr);
      chk("mem_space", mv ? DPU_SP_XDATA : (c == DPU_OP_CRD && m_cfg[3]) ? DPU_SP_SIGN :
        DPU_SP_CODE, mem_space);
      chk("mem_use_b", s && m_sp[0] && c != DPU_OP_JMP, mem_use_b);
    end
  endtask : do_op

  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    rd_all();
    $display("test reset values done");
    wr(8'h10, 8'h5a);
    wr(DPU_IDX_PTR_CFG, 8'hff);
    rd_all();
    wr(DPU_IDX_PTR_CFG, 8'hfa);
    wr(DPU_IDX_PTR0_LO, 8'h34);
    wr(DPU_IDX_PTR1_HI, 8'h12);
    rd_all();
    $display("test register access done");
    for (int k = 0; k < 800; k++) begin
      r = xs();
      if (k % 16 == 0) begin
        wr(DPU_IDX_PTR_CFG, r[7:0]);
        wr(DPU_IDX_SP_CFG, r[15:8]);
        wr(DPU_IDX_BUF_LEN, r[17:16] == 2'b00 ? 8'hff : r[31:24]);
      end
      r = xs();
      imm = r[4] ? r[31:16] : {7'h00, r[2], r[3] ? m_len : 8'h00};
      do_op(dpu_op_t'(r[7:5] == 3'h7 ? 3'h1 : r[7:5]), r[8], r[15:8], imm);
    end
    rd_all();
    $display("test random operations done");
    stop_test();
  end
endmodule : dual_pointer_update_unit_test
